// File: logic/xrc_flash_cmd.sv
// xspi flash command interpreter for register and enable commands
`include "xrc_params.svh"
module xrc_flash_cmd
    import xrc_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_CYCLES =
        (`XRC_STATUS_WRITE_TIME_NS * `XRC_CLK_MHZ) / 1000,
    parameter int unsigned NVCFG_WRITE_CYCLES =
        (`XRC_NONVOLATILE_CFG_WRITE_TIME_NS * `XRC_CLK_MHZ) / 1000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chipSelectPin_n,
    input wire logic serialClockPin,
    input wire logic [7:0] dqIn,
    input wire logic writeProtectPin_n,
    input wire logic octalProto,
    input wire logic ddrProto,
    input wire logic addr4Byte,
    input wire logic eraseErrSet,
    input wire logic progErrSet,
    input wire logic protErrSet,
    output logic [7:0] dqOut,
    output logic [7:0] dqOe,
    output logic writeEnableLatch,
    output logic writeInProgress,
    output logic [5:0] protBits,
    output logic flagProtErr,
    output logic [7:0] nvCfg,
    output logic [7:0] vCfg,
    output logic arrayReadStart,
    output logic [31:0] arrayReadAddr
);
    ////////////////////////////////////////////////////////////////
    // synchronised pins
    logic csS; // chip select, active low
    logic wpS_n; // write protect, active low
    logic sclkS; // serial clock
    logic [7:0] dqS; // data lines

    // pin synchroniser
    xrc_sync #(
        .W(11),
        .RST({1'b1, 1'b1, 1'b0, 8'h00})
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({chipSelectPin_n, writeProtectPin_n, serialClockPin, dqIn}),
        .dout({csS, wpS_n, sclkS, dqS})
    );

    xrc_state_t s; // registered state
    xrc_state_t next_s; // next state

    ////////////////////////////////////////////////////////////////
    // address bytes per opcode
    function automatic logic [2:0] addrBytes(input logic [7:0] op, input logic octDdr, input logic a4);
        logic [2:0] n;
        n = a4 ? `XRC_ADDR4 : `XRC_ADDR3; // configured length
        if (octDdr)
        begin
            n = `XRC_ADDR4; // octal DDR always four bytes
        end
        else if (op == OP_DDRIO || op == OP_OCTIO4)
        begin
            n = `XRC_ADDR4; // four-byte commands
        end
        return n;
    endfunction

    // phase after the opcode
    function automatic xrc_phase_t afterCmd(input logic [7:0] op);
        xrc_phase_t p;
        p = PH_SKIP;
        unique case (op)
            OP_WREN, OP_WRDI, OP_CLRFLAG: p = PH_DONE;
            OP_RDSR, OP_RDFLAG: p = PH_DOUT; // accepted even while busy
            OP_WRSR: p = PH_DIN;
            OP_RDNVCFG, OP_RDVCFG, OP_WRNVCFG, OP_WRVCFG: p = PH_ADDR;
            OP_OCTIO, OP_OCTIO4, OP_DDROUT, OP_DDRIO: p = PH_ADDR;
            default: p = PH_SKIP; // unknown opcodes are skipped
        endcase
        return p;
    endfunction

    // fast read family
    function automatic logic isFastRead(input logic [7:0] op);
        return op == OP_OCTIO || op == OP_OCTIO4 || op == OP_DDROUT || op == OP_DDRIO;
    endfunction

    ////////////////////////////////////////////////////////////////
    // decode helpers
    logic rise; // serial clock rising edge
    logic fall; // serial clock falling edge
    logic octDdr; // octal DDR protocol
    logic ddrNow; // both edges carry data
    logic wide; // all eight lines in use
    logic beatIn; // input beat this cycle
    logic outEdge; // output edge this cycle
    logic [7:0] shiftNext; // shift value with beat
    logic byteDone; // beat completes a byte
    logic [7:0] readByte; // register value to send
    logic [31:0] addrNext; // address with byte

    // edge, width and rate decode
    always_comb
    begin
        rise = sclkS && !s.sclkPrev;
        fall = !sclkS && s.sclkPrev;
        octDdr = octalProto && ddrProto;
        // DDR opcodes run DDR after a single-rate opcode
        ddrNow = octDdr || (s.phase == PH_ADDR && (s.opcode == OP_DDROUT || s.opcode == OP_DDRIO));
        // line 0 in extended except fast-read addresses other than DDROUT, all lines in octal
        wide = octalProto || (s.phase == PH_ADDR && s.opcode != OP_DDROUT && isFastRead(s.opcode));
        beatIn = (rise || (ddrNow && fall)) && !csS
            && (s.phase == PH_CMD || s.phase == PH_CMDX || s.phase == PH_ADDR
            || s.phase == PH_DIN || s.phase == PH_DONE);
        outEdge = !csS && s.phase == PH_DOUT && (fall || (octDdr && rise));
        shiftNext = wide ? dqS : {s.shift[6:0], dqS[0]};
        byteDone = wide || s.bitInByte == 3'h7;
        addrNext = {s.addr[23:0], shiftNext};
    end

    // byte offered by the selected read
    always_comb
    begin
        readByte = {s.protBits, s.wel, s.wip};
        if (s.opcode == OP_RDFLAG)
        begin
            readByte = 8'h00;
            readByte[`XRC_FS_READY] = !s.wip;
            readByte[`XRC_FS_ERASE] = s.eraseErr;
            readByte[`XRC_FS_PROG] = s.progErr;
            readByte[`XRC_FS_PROT] = s.protErr;
        end
        else if (s.opcode == OP_RDNVCFG)
        begin
            readByte = s.nvCfg | `XRC_CFG_RSVD_MASK;
        end
        else if (s.opcode == OP_RDVCFG)
        begin
            readByte = s.vCfg | `XRC_CFG_RSVD_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        next_s = s;
        next_s.sclkPrev = sclkS;
        next_s.csPrev = csS;
        next_s.rdStart = 1'b0;

        // self-timed register write
        if (s.wip)
        begin
            if (s.busyCnt <= 24'h1)
            begin
                if (s.pendNv)
                begin
                    next_s.nvCfg = s.pendData;
                end
                else
                begin
                    next_s.protBits = s.pendData[7:2]; // bits 1:0 untouched
                end
                next_s.wip = 1'b0; // done, pass or fail
                next_s.wel = 1'b0;
            end
            else
            begin
                next_s.busyCnt = s.busyCnt - 24'h1;
            end
        end

        if (csS)
        begin
            // frame over: output released
            next_s.phase = PH_IDLE;
            next_s.dqOe = 8'h00; // chip select ends reads
            // only a frame ending on an exact byte, or a flag clear with extra bits, reaches here
            if (!s.csPrev && s.phase == PH_DONE)
            begin
                unique case (s.opcode)
                    OP_WREN:
                    begin
                        if (!s.wip)
                        begin
                            next_s.wel = 1'b1;
                        end
                    end
                    OP_WRDI:
                    begin
                        if (!s.wip && !s.protErr)
                        begin
                            next_s.wel = 1'b0; // latch held after protection error
                        end
                    end
                    OP_CLRFLAG:
                    begin
                        next_s.eraseErr = 1'b0;
                        next_s.progErr = 1'b0;
                        next_s.protErr = 1'b0;
                        if (!s.wip)
                        begin
                            next_s.wel = 1'b0; // clears latch too
                        end
                    end
                    OP_WRSR:
                    begin
                        if (s.wel && !s.wip)
                        begin
                            if (s.protBits[`XRC_SR_SRWD] && !wpS_n)
                            begin
                                next_s.wel = 1'b0; // pin-locked, refused
                            end
                            else
                            begin
                                next_s.wip = 1'b1;
                                next_s.pendNv = 1'b0;
                                next_s.pendData = s.dataByte;
                                next_s.busyCnt = 24'(STATUS_WRITE_CYCLES);
                            end
                        end
                    end
                    OP_WRNVCFG:
                    begin
                        if (s.wel && !s.wip)
                        begin
                            next_s.wip = 1'b1;
                            next_s.pendNv = 1'b1;
                            next_s.pendData = s.dataByte;
                            next_s.busyCnt = 24'(NVCFG_WRITE_CYCLES);
                        end
                    end
                    OP_WRVCFG:
                    begin
                        if (s.wel && !s.wip)
                        begin
                            // immediate, reserved bits kept
                            next_s.vCfg = (s.vCfg & `XRC_CFG_RSVD_MASK)
                                | (s.dataByte & ~`XRC_CFG_RSVD_MASK);
                            next_s.wel = 1'b0;
                        end
                    end
                    default:
                    begin
                        next_s.phase = PH_IDLE; // nothing to run
                    end
                endcase
            end
        end
        else if (s.csPrev)
        begin
            // frame start
            next_s.phase = PH_CMD;
            next_s.bitInByte = 3'h0;
            next_s.dqOe = 8'h00;
        end
        else if (beatIn)
        begin
            // collect one beat
            next_s.shift = shiftNext;
            next_s.bitInByte = wide ? 3'h0 : s.bitInByte + 3'h1;
            // any beat past the last whole byte voids the frame, flag-clear excepted
            if (s.phase == PH_DONE && s.opcode != OP_CLRFLAG)
            begin
                next_s.phase = PH_SKIP;
            end
            if (byteDone)
            begin
                unique case (s.phase)
                    PH_CMD:
                    begin
                        next_s.opcode = shiftNext;
                        next_s.addrLeft = addrBytes(shiftNext, octDdr, addr4Byte);
                        // octal DDR opcode has a second beat
                        next_s.phase = octDdr ? PH_CMDX : afterCmd(shiftNext);
                    end
                    PH_CMDX:
                    begin
                        next_s.phase = afterCmd(s.opcode);
                    end
                    PH_ADDR:
                    begin
                        next_s.addr = addrNext;
                        next_s.addrLeft = s.addrLeft - 3'h1;
                        if (s.addrLeft == 3'h1)
                        begin
                            if (isFastRead(s.opcode))
                            begin
                                // full address handed to array reader
                                next_s.rdStart = 1'b1;
                                next_s.rdAddr = addrNext;
                                next_s.phase = PH_SKIP;
                            end
                            else if (s.opcode == OP_RDNVCFG || s.opcode == OP_RDVCFG)
                            begin
                                next_s.phase = PH_DOUT;
                            end
                            else
                            begin
                                next_s.phase = PH_DIN;
                            end
                        end
                    end
                    PH_DIN:
                    begin
                        next_s.dataByte = shiftNext;
                        next_s.phase = PH_DONE;
                    end
                    PH_DONE:
                    begin
                        // extra bits void the frame, flag-clear excepted
                        if (s.opcode != OP_CLRFLAG)
                        begin
                            next_s.phase = PH_SKIP;
                        end
                    end
                    PH_IDLE, PH_DOUT, PH_SKIP:
                    begin
                        next_s.phase = s.phase;
                    end
                endcase
            end
        end
        else if (outEdge)
        begin
            // shift out the selected register, repeating it
            if (octalProto)
            begin
                next_s.dqOut = readByte;
                next_s.dqOe = `XRC_OE_ALL;
            end
            else
            begin
                next_s.dqOe = 8'h00;
                next_s.dqOe[`XRC_SERIAL_OUT_LINE] = 1'b1;
                next_s.dqOut = 8'h00;
                if (s.bitInByte == 3'h0)
                begin
                    next_s.dqOut[`XRC_SERIAL_OUT_LINE] = readByte[7];
                    next_s.shift = {readByte[6:0], 1'b0};
                end
                else
                begin
                    next_s.dqOut[`XRC_SERIAL_OUT_LINE] = s.shift[7];
                    next_s.shift = {s.shift[6:0], 1'b0};
                end
                next_s.bitInByte = s.bitInByte + 3'h1;
            end
        end

        // error events win over a same-cycle clear
        if (eraseErrSet)
        begin
            next_s.eraseErr = 1'b1;
        end
        if (progErrSet)
        begin
            next_s.progErr = 1'b1;
        end
        if (protErrSet)
        begin
            next_s.protErr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '{
                phase: PH_IDLE,
                sclkPrev: 1'b0,
                csPrev: 1'b1,
                shift: 8'h00,
                bitInByte: 3'h0,
                opcode: 8'h00,
                addr: 32'h0,
                addrLeft: 3'h0,
                dataByte: 8'h00,
                protBits: 6'h00,
                wel: 1'b0,
                wip: 1'b0,
                pendNv: 1'b0,
                pendData: 8'h00,
                busyCnt: 24'h0,
                eraseErr: 1'b0,
                progErr: 1'b0,
                protErr: 1'b0,
                nvCfg: `XRC_NVCFG_RESET,
                vCfg: `XRC_VCFG_RESET,
                dqOut: 8'h00,
                dqOe: 8'h00,
                rdStart: 1'b0,
                rdAddr: 32'h0
            };
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs straight from state
    assign dqOut = s.dqOut;
    assign dqOe = s.dqOe;
    assign writeEnableLatch = s.wel;
    assign writeInProgress = s.wip;
    assign protBits = s.protBits;
    assign flagProtErr = s.protErr;
    assign nvCfg = s.nvCfg;
    assign vCfg = s.vCfg;
    assign arrayReadStart = s.rdStart;
    assign arrayReadAddr = s.rdAddr;
endmodule

// File: logic/xrc_params.svh
// constants for the xspi register command interpreter
`ifndef XRC_PARAMS_SVH
`define XRC_PARAMS_SVH
// system clock rate
`define XRC_CLK_MHZ 25
// self-timed write durations, in ns
`define XRC_STATUS_WRITE_TIME_NS 1000000
`define XRC_NONVOLATILE_CFG_WRITE_TIME_NS 1000000
// status register bit positions; SRWD is a protBits index, status bit 7
`define XRC_SR_WIP 0
`define XRC_SR_WEL 1
`define XRC_SR_SRWD 5
// flag status bit positions
`define XRC_FS_READY 7
`define XRC_FS_ERASE 5
`define XRC_FS_PROG 4
`define XRC_FS_PROT 1
// reserved config bits, forced to one on read
`define XRC_CFG_RSVD_MASK 8'hc0
// config register reset values
`define XRC_NVCFG_RESET 8'hff
`define XRC_VCFG_RESET 8'hff
// address lengths in bytes
`define XRC_ADDR3 3'h3
`define XRC_ADDR4 3'h4
// data line used for extended protocol output
`define XRC_SERIAL_OUT_LINE 1
// drive patterns
`define XRC_OE_ALL 8'hff
`endif

// File: logic/xrc_pkg.sv
// types for the xspi register command interpreter
package xrc_pkg;
    // frame phases
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CMD = 3'b001,
        PH_CMDX = 3'b010,
        PH_ADDR = 3'b011,
        PH_DIN = 3'b100,
        PH_DOUT = 3'b101,
        PH_DONE = 3'b110,
        PH_SKIP = 3'b111
    } xrc_phase_t;
    // opcodes understood by the interpreter
    typedef enum logic [7:0] {
        OP_WRSR = 8'h01,
        OP_WRDI = 8'h04,
        OP_RDSR = 8'h05,
        OP_WREN = 8'h06,
        OP_CLRFLAG = 8'h50,
        OP_RDFLAG = 8'h70,
        OP_WRVCFG = 8'h81,
        OP_RDVCFG = 8'h85,
        OP_DDROUT = 8'h9d,
        OP_WRNVCFG = 8'hb1,
        OP_RDNVCFG = 8'hb5,
        OP_OCTIO = 8'hcb,
        OP_OCTIO4 = 8'hcc,
        OP_DDRIO = 8'hfd
    } xrc_op_t;
    // whole interpreter state
    typedef struct packed {
        xrc_phase_t phase;
        logic sclkPrev;
        logic csPrev;
        logic [7:0] shift;
        logic [2:0] bitInByte;
        logic [7:0] opcode;
        logic [31:0] addr;
        logic [2:0] addrLeft;
        logic [7:0] dataByte;
        logic [5:0] protBits;
        logic wel;
        logic wip;
        logic pendNv;
        logic [7:0] pendData;
        logic [23:0] busyCnt;
        logic eraseErr;
        logic progErr;
        logic protErr;
        logic [7:0] nvCfg;
        logic [7:0] vCfg;
        logic [7:0] dqOut;
        logic [7:0] dqOe;
        logic rdStart;
        logic [31:0] rdAddr;
    } xrc_state_t;
endpackage

// File: logic/xrc_sync.sv
// two-flop synchroniser for pin inputs
module xrc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // both stages in one state word
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } xrc_sync_t;

    xrc_sync_t s; // registered stages
    xrc_sync_t next_s; // next stages

    ////////////////////////////////////////////////////////////////
    // first stage only feeds the second
    always_comb
    begin
        next_s.meta = din;
        next_s.stable = s.meta;
    end

    // register both stages
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '{meta: RST, stable: RST};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign dout = s.stable;
endmodule

// File: verif/xrc_flash_cmd_assertions.sv
// concurrent checks on the register command interpreter ports
module xrc_flash_cmd_assertions #(
    parameter int unsigned STATUS_WRITE_CYCLES = 20,
    parameter int unsigned NVCFG_WRITE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chipSelectPin_n,
    input wire logic octalProto,
    input wire logic [7:0] dqOe,
    input wire logic writeEnableLatch,
    input wire logic writeInProgress,
    input wire logic [5:0] protBits,
    input wire logic flagProtErr,
    input wire logic arrayReadStart
);
    timeunit 1ns;
    timeprecision 100ps;
    // shortest and longest timed write
    localparam int unsigned LO = STATUS_WRITE_CYCLES < NVCFG_WRITE_CYCLES ? STATUS_WRITE_CYCLES : NVCFG_WRITE_CYCLES;
    localparam int unsigned HI = STATUS_WRITE_CYCLES < NVCFG_WRITE_CYCLES ? NVCFG_WRITE_CYCLES : STATUS_WRITE_CYCLES;
    logic [23:0] busyLen; // cycles of the current timed write
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // busy length counter
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            busyLen <= 24'h000000;
        else if (writeInProgress)
            busyLen <= busyLen + 24'h000001;
        else
            busyLen <= 24'h000000;
    end
    ////////////////////////////////////////////////////////////////
    a_oe_idle: assert property (chipSelectPin_n [*6] |-> dqOe == 8'h00)
        else $error("lines driven while deselected");
    a_ext_line: assert property (!octalProto |-> (dqOe & 8'hfd) == 8'h00)
        else $error("extended mode drives a line other than one");
    a_oct_all: assert property (octalProto && dqOe != 8'h00 |-> dqOe == 8'hff)
        else $error("octal mode drives only some lines");
    a_busy_len: assert property ($fell(writeInProgress) |-> busyLen + 24'h000001 >= LO && busyLen <= HI + 1)
        else $error("timed write length wrong");
    a_wel_end: assert property ($fell(writeInProgress) |-> ##[0:2] !writeEnableLatch)
        else $error("latch still set after timed write");
    a_wip_start: assert property ($rose(writeInProgress) |-> $past(writeEnableLatch) && $past(chipSelectPin_n, 2))
        else $error("timed write started without latch or frame end");
    a_prot_hold: assert property ($changed(protBits) |-> $past(writeInProgress) || $past(writeInProgress, 2))
        else $error("protection bits changed outside a status write");
    a_flag_clear: assert property ($fell(flagProtErr) |-> ##[0:1] !writeEnableLatch)
        else $error("flag clear left latch set");
    a_read_pulse: assert property (arrayReadStart |=> !arrayReadStart)
        else $error("read start longer than one cycle");
    c_timed_write: cover property ($fell(writeInProgress));
    c_flag_clear: cover property ($fell(flagProtErr));
    c_read_start: cover property (arrayReadStart);
    c_oct_drive: cover property (dqOe == 8'hff);
endmodule

// File: verif/xrc_host_model.sv
// host controller model driving chip select, serial clock and data lines
module xrc_host_model (
    input wire logic clk,
    input wire logic octalProto,
    input wire logic [7:0] dqOut,
    output logic chipSelectPin_n,
    output logic serialClockPin,
    output logic [7:0] dqIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle pins at time zero
    initial
    begin
        chipSelectPin_n = 1'b1;
        serialClockPin = 1'b0;
        dqIn = 8'h00;
    end
    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // select the device, clock parked low
    task automatic open();
        tick(1);
        chipSelectPin_n = 1'b0;
        tick(4);
    endtask
    // n bits msb first, each copied to all eight lines, or one octal beat
    task automatic sendb(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            // data moves well clear of the falling edge, which samples in DDR
            tick(2);
            dqIn = octalProto ? b : {8{b[i]}};
            tick(2);
            serialClockPin = 1'b1;
            tick(4);
            serialClockPin = 1'b0;
            if (octalProto)
                break;
        end
    endtask
    // sample line one per bit, or the whole byte in octal
    task automatic recvb(output logic [7:0] v);
        for (int i = 0; i < (octalProto ? 1 : 8); i++)
        begin
            tick(5);
            v = octalProto ? dqOut : {v[6:0], dqOut[1]};
            serialClockPin = 1'b1;
            tick(4);
            serialClockPin = 1'b0;
        end
    endtask
    // deselect right after the last whole byte; released lines flip
    task automatic close();
        tick(4);
        chipSelectPin_n = 1'b1;
        dqIn = ~dqIn;
        tick(8);
    endtask
endmodule

// File: verif/xrc_flash_cmd_bench.sv
// self-checking bench for the flash register command interpreter
module xrc_flash_cmd_bench import xrc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned WCYC = 300; // shortened timed write
    logic clk = 1'b0;
    logic resetn, chipSelectPin_n, serialClockPin, octalProto, addr4Byte, ddrProto, writeProtectPin_n;
    logic eraseErrSet, progErrSet, protErrSet, writeEnableLatch, writeInProgress, flagProtErr, arrayReadStart;
    logic [7:0] dqIn, dqOut, dqOe, nvCfg, vCfg, d;
    logic [5:0] protBits;
    logic [31:0] arrayReadAddr, a;
    logic [31:0] lfsr = 32'ha0a795eb; // random source
    logic [7:0] expV = 8'hff; // expected volatile config
    int errors = 0;
    int num_checks = 0;
    ////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;
    xrc_flash_cmd #(.STATUS_WRITE_CYCLES(WCYC), .NVCFG_WRITE_CYCLES(WCYC)) i_xrc_flash_cmd (.*);
    xrc_host_model host (.clk(clk), .octalProto(octalProto), .dqOut(dqOut), .chipSelectPin_n(chipSelectPin_n),
        .serialClockPin(serialClockPin), .dqIn(dqIn));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // reserved bits keep their stored value
    function automatic logic [7:0] vmerge(input logic [7:0] old, input logic [7:0] v);
        return (old & 8'hc0) | (v & 8'h3f);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // opcode then address bytes msb first
    task automatic hdr(input logic [7:0] op, input int na, input logic [31:0] ad);
        host.open();
        host.sendb(op, 8);
        for (int i = na - 1; i >= 0; i--)
            host.sendb(ad[8*i +: 8], 8);
    endtask
    task automatic cmd(input logic [7:0] op);
        hdr(op, 0, 32'h0);
        host.close();
    endtask
    task automatic wr(input logic [7:0] op, input int na, input logic [7:0] v);
        hdr(op, na, rnd());
        host.sendb(v, 8);
        host.close();
    endtask
    // two bytes read back to back
    task automatic rd2(input logic [7:0] op, input int na, input logic [7:0] exp);
        logic [7:0] v;
        hdr(op, na, rnd());
        repeat (2)
        begin
            host.recvb(v);
            chk(v, exp);
        end
        host.close();
    endtask
    ////////////////////////////////////////////////////////////////
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    // main sequence
    initial
    begin
        resetn = 1'b0;
        {octalProto, ddrProto, addr4Byte, eraseErrSet, progErrSet, protErrSet} = 6'h00;
        writeProtectPin_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        host.tick(4);
        cmd(OP_WREN);
        chk(writeEnableLatch, 1'b1);
        cmd(OP_WRDI);
        chk(writeEnableLatch, 1'b0);
        host.open();
        host.sendb(OP_WREN, 8);
        host.sendb(8'h00, 1);
        host.close();
        chk(writeEnableLatch, 1'b0);
        wr(OP_WRSR, 0, 8'hfc);
        chk(protBits, 6'h00);
        d = 8'(rnd()) | 8'h80; // top bit locks status writes while the pin is low
        cmd(OP_WREN);
        wr(OP_WRSR, 0, d);
        rd2(OP_RDSR, 0, 8'h03);
        host.tick(WCYC);
        chk(protBits, d[7:2]);
        rd2(OP_RDSR, 0, {d[7:2], 2'b00});
        writeProtectPin_n = 1'b0;
        cmd(OP_WREN);
        wr(OP_WRSR, 0, 8'h00);
        chk({protBits, writeEnableLatch}, {d[7:2], 1'b0});
        octalProto = 1'b1;
        repeat (3)
        begin
            d = rnd();
            expV = vmerge(expV, d);
            cmd(OP_WREN);
            chk(writeEnableLatch, 1'b1);
            wr(OP_WRVCFG, 3, d);
            chk(vCfg, expV);
        end
        addr4Byte = 1'b1;
        rd2(OP_RDVCFG, 4, expV);
        d = 8'(rnd() & 32'h3f);
        cmd(OP_WREN);
        wr(OP_WRNVCFG, 4, d);
        chk(writeInProgress, 1'b1);
        host.tick(WCYC);
        rd2(OP_RDNVCFG, 4, d | 8'hc0);
        a = rnd();
        hdr(OP_OCTIO, 4, a);
        host.close();
        chk(arrayReadAddr, a);
        addr4Byte = 1'b0;
        a = rnd();
        hdr(OP_OCTIO4, 4, a);
        host.close();
        chk(arrayReadAddr, a);
        ddrProto = 1'b1;
        a = rnd() & 32'hfffe; // even byte address
        hdr(OP_DDRIO, 2, a); // each byte rides a rise and a fall
        host.close();
        chk(arrayReadAddr, {{2{a[15:8]}}, {2{a[7:0]}}});
        ddrProto = 1'b0;
        {eraseErrSet, progErrSet, protErrSet} = 3'b111;
        host.tick(1);
        {eraseErrSet, progErrSet, protErrSet} = 3'b000;
        rd2(OP_RDFLAG, 0, 8'hb2);
        cmd(OP_WREN);
        cmd(OP_WRDI);
        chk(writeEnableLatch, 1'b1);
        cmd(OP_CLRFLAG);
        chk({flagProtErr, writeEnableLatch}, 2'b00);
        rd2(OP_RDFLAG, 0, 8'h80);
        complete_run();
    end
endmodule
bind xrc_flash_cmd xrc_flash_cmd_assertions #(
    .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES), .NVCFG_WRITE_CYCLES(NVCFG_WRITE_CYCLES)) i_chk (.*);
